// ===== rtl/protect_cfg.svh
// constants for the motor protection fault monitor
`ifndef PROTECT_CFG_SVH
`define PROTECT_CFG_SVH

// ==========================================
// register offsets
`define OFS_CTRL    8'h00
`define OFS_FLC     8'h04
`define OFS_VOLT    8'h08
`define OFS_UL      8'h0c
`define OFS_UV      8'h10
`define OFS_OV      8'h14
`define OFS_UB      8'h18
`define OFS_STALL   8'h1c
`define OFS_JAM     8'h20
`define OFS_GF      8'h24
`define OFS_GFI     8'h28
`define OFS_GFA     8'h2c
`define OFS_STATUS  8'h30
`define OFS_THERM   8'h34

// ==========================================
// control fields and reset values
`define CTRL_AUTO_BIT   3
`define CTRL_GFT_BIT    4
`define CTRL_GFA_BIT    5
`define CTRL_PTC_BIT    6
`define CTRL_RESET_BIT  8
`define CLASS_OFF       3'h0
`define CLASS_10        3'h1
`define CLASS_30        3'h4
`define CTRL_RST        32'h0000_0001
`define FLC_RST         32'h0000_0064

// ==========================================
// thresholds and timing
`define THERM_FULL      14'h2710
`define THERM_AUTO_LVL  14'h1d4c
`define OL_TRIP_PCT     10'h075
`define GF_ARM_CUR      16'h0032
`define MIN_FLA_PCT     10'h01e
`define PTC_RESP_OHM    16'h0d48
`define PTC_RESET_OHM   16'h0640
`define PTC_SHORT_OHM   16'h0019
`define PTC_RESP_MS     800
`define TENTH_MS        100
`define PCLK_NS         5
`define GF_LO_SMALL     12'h064
`define GF_HI_SMALL     12'h1f4
`define GF_LO_LARGE     12'h1f4
`define GF_HI_LARGE     12'h9c4

`endif

// ===== rtl/protect_pkg.sv
// types for the motor protection fault monitor
package protect_pkg;

  typedef enum logic [2:0]
  {
    ST_STOPPED = 3'b001,
    ST_RUNNING = 3'b010,
    ST_TRIPPED = 3'b100
  } run_state_type;

  typedef enum logic [3:0]
  {
    CAUSE_NONE       = 4'h0,
    CAUSE_OVERLOAD   = 4'h1,
    CAUSE_UNDERLOAD  = 4'h2,
    CAUSE_UNDERVOLT  = 4'h3,
    CAUSE_OVERVOLT   = 4'h4,
    CAUSE_UNBALANCE  = 4'h5,
    CAUSE_JAM        = 4'h6,
    CAUSE_STALL      = 4'h7,
    CAUSE_GROUND     = 4'h8,
    CAUSE_THERMISTOR = 4'h9
  } fault_cause_type;

endpackage

// ===== rtl/persist_timer.sv
// persistence timer: flags a condition held longer than a limit in tenths
`timescale 1ns/1ps
module persist_timer #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // timing
  input  wire logic         tick,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  // result
  output logic              expired
);

  logic [W-1:0] cnt_r;

  // count saturates so a long fault never wraps back to quiet
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (!cond)
      cnt_r <= '0;
    else if (tick && (cnt_r != {W{1'b1}}))
      cnt_r <= cnt_r + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      expired <= 1'b0;
    else
      expired <= cond && (cnt_r > limit);
  end

endmodule

// ===== rtl/motor_protect.sv
// motor protection supervisor with apb register access
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "protect_cfg.svh"

// Behaviour
// - overload trip at full thermal usage
// - thermal usage kept, restorable by software
// - class off/10/15/20/30, default 10
// - auto reset restarts only after start cycled
// - overload pickup at 117 percent FLC
// - underload trip after programmable delay
// - underload ignored in slow speed, braking
// - undervoltage trip after programmable delay
// - overvoltage trip after programmable delay
// - voltage unbalance trip after programmable delay
// - voltage checks ignored while braking
// - pre-fault alarms close alarm contact
// - stall allows extra time past ramp
// - jam trip on level and delay
// - jam ignored in slow speed, braking
// - ground trip needs enable, inhibit, persistence
// - ground inhibit interval 0 to 255 s
// - ground trip delay programmable in tenths
// - ground level range set by size
// - inhibit starts on current or leakage
// - ground alarm needs no other warning
// - ground alarm persistence delay
// - thermistor thresholds and 800 ms response
// - thermistor trip when enabled, no fault
module motor_protect
  import protect_pkg::*;
#(
  parameter int TICK_CYCLES  = `TENTH_MS * 1000000 / `PCLK_NS,
  parameter int MIN_FLA_DECI = 10
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // measurements, same clock, current in 0.1 A, leakage in 0.01 A
  input  wire logic [15:0] phase_current_max,
  input  wire logic [15:0] line_voltage_min,
  input  wire logic [15:0] line_voltage_max,
  input  wire logic [7:0]  unbalance_pct,
  input  wire logic [15:0] ground_leak_current,
  input  wire logic [15:0] ptc_ohms,
  // operating mode from the power stage
  input  wire logic        slow_speed,
  input  wire logic        braking,
  input  wire logic        ramping,
  input  wire logic        up_to_speed,
  input  wire logic        large_frame,
  // start pin, asynchronous
  input  wire logic        start_pin,
  // indication and control
  output logic             run_enable,
  output logic             fault_active,
  output logic             alarm_contact,
  output logic [3:0]       fault_cause,
  output logic [13:0]      therm_usage
);

  localparam int NT = 11;
  localparam int T_UL = 0, T_UV = 1, T_OV = 2, T_UB = 3, T_JAM = 4, T_STALL = 5;
  localparam int T_GF = 6, T_PTC = 7, T_GFA = 8, T_STALM = 9, T_INH = 10;
  localparam logic [11:0] PTC_TICKS = 12'(`PTC_RESP_MS / `TENTH_MS - 1);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ==========================================
  // helpers
  function automatic logic below_pct(input logic [15:0] v, input logic [15:0] r, input logic [9:0] p);
    below_pct = ({16'h0, v} * 32'd100) < ({16'h0, r} * {22'h0, p});
  endfunction

  function automatic logic above_pct(input logic [15:0] v, input logic [15:0] r, input logic [9:0] p);
    above_pct = ({16'h0, v} * 32'd100) > ({16'h0, r} * {22'h0, p});
  endfunction

  function automatic logic [11:0] tenths(input logic [7:0] s);
    tenths = 12'({4'h0, s} * 12'd10);
  endfunction

  // ==========================================
  // registers
  logic [2:0]  ol_class_r;
  logic        ol_auto_r, gf_trip_en_r, gf_alarm_en_r, ptc_en_r, reset_req_r;
  logic [15:0] flc_r, volt_r;
  logic [31:0] ul_r, uv_r, ov_r, ub_r, stall_r, jam_r, gf_r, gfi_r, gfa_r;
  logic [13:0] therm_r;
  run_state_type   state_r;
  fault_cause_type cause_r;
  logic [NT-1:0]   cond, expd;
  logic [11:0]     limit [NT];
  logic            alarm_r, start_armed_r, inh_started_r, tick;

  wire logic wr_en = psel && penable && pwrite && !pslverr;
  wire logic running = (state_r == ST_RUNNING);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OFS_THERM);
  endfunction

  // ==========================================
  // apb slave, zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ol_class_r    <= 3'(`CTRL_RST);
      ol_auto_r     <= 1'b0;
      gf_trip_en_r  <= 1'b0;
      gf_alarm_en_r <= 1'b0;
      ptc_en_r      <= 1'b0;
      flc_r         <= 16'(`FLC_RST);
      volt_r        <= 16'h0190;
      ul_r          <= 32'h0;
      uv_r          <= 32'h0;
      ov_r          <= 32'h0000_00c7;
      ub_r          <= 32'h0000_1919;
      stall_r       <= 32'h0;
      jam_r         <= 32'h0000_03e8;
      gf_r          <= 32'h0000_09c4;
      gfi_r         <= 32'h0;
      gfa_r         <= 32'h0000_09c4;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `OFS_CTRL:
        begin
          if (pwdata[2:0] <= `CLASS_30)
            ol_class_r <= pwdata[2:0];
          ol_auto_r     <= pwdata[`CTRL_AUTO_BIT];
          gf_trip_en_r  <= pwdata[`CTRL_GFT_BIT];
          gf_alarm_en_r <= pwdata[`CTRL_GFA_BIT];
          ptc_en_r      <= pwdata[`CTRL_PTC_BIT];
        end
        `OFS_FLC:   flc_r   <= pwdata[15:0];
        `OFS_VOLT:  volt_r  <= pwdata[15:0];
        `OFS_UL:    ul_r    <= pwdata;
        `OFS_UV:    uv_r    <= pwdata;
        `OFS_OV:    ov_r    <= pwdata;
        `OFS_UB:    ub_r    <= pwdata;
        `OFS_STALL: stall_r <= pwdata;
        `OFS_JAM:   jam_r   <= pwdata;
        `OFS_GF:    gf_r    <= pwdata;
        `OFS_GFI:   gfi_r   <= pwdata;
        `OFS_GFA:   gfa_r   <= pwdata;
        default:    ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_req_r <= 1'b0;
    else
      reset_req_r <= wr_en && (paddr == `OFS_CTRL) && pwdata[`CTRL_RESET_BIT];
  end

  // read data captured in the setup phase so it is stable for the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable)
    begin
      unique case (paddr)
        `OFS_CTRL:   prdata <= {25'h0, ptc_en_r, gf_alarm_en_r, gf_trip_en_r, ol_auto_r, ol_class_r};
        `OFS_FLC:    prdata <= {16'h0, flc_r};
        `OFS_VOLT:   prdata <= {16'h0, volt_r};
        `OFS_UL:     prdata <= ul_r;
        `OFS_UV:     prdata <= uv_r;
        `OFS_OV:     prdata <= ov_r;
        `OFS_UB:     prdata <= ub_r;
        `OFS_STALL:  prdata <= stall_r;
        `OFS_JAM:    prdata <= jam_r;
        `OFS_GF:     prdata <= gf_r;
        `OFS_GFI:    prdata <= gfi_r;
        `OFS_GFA:    prdata <= gfa_r;
        `OFS_STATUS: prdata <= {20'h0, expd[T_GFA], expd[T_STALM], alarm_r, start_armed_r, cause_r, 1'b0, state_r};
        `OFS_THERM:  prdata <= {18'h0, therm_r};
        default:     prdata <= 32'h0;
      endcase
    end
  end

  // ==========================================
  // tenth-second tick
  logic [TW-1:0] tick_cnt_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_r <= '0;
    else if (tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 1'b1;
  end

  assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));

  // ==========================================
  // start pin: three stages, change accepted when the last two agree
  logic [2:0] start_sync_r;
  logic       start_lvl_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_sync_r <= 3'h0;
      start_lvl_r  <= 1'b0;
    end
    else
    begin
      start_sync_r <= {start_sync_r[1:0], start_pin};
      if (start_sync_r[1] == start_sync_r[2])
        start_lvl_r <= start_sync_r[2];
    end
  end

  // ==========================================
  // thermal model; software write restores the saved value after power loss
  logic ol_over, ol_full;
  logic [13:0] ol_rate;

  always_comb
  begin
    unique case (ol_class_r)
      3'h1:    ol_rate = 14'd100;
      3'h2:    ol_rate = 14'd67;
      3'h3:    ol_rate = 14'd50;
      3'h4:    ol_rate = 14'd33;
      default: ol_rate = 14'd0;
    endcase
  end

  assign ol_over = (ol_class_r != `CLASS_OFF) && above_pct(phase_current_max, flc_r, `OL_TRIP_PCT);
  assign ol_full = (ol_class_r != `CLASS_OFF) && (therm_r >= `THERM_FULL);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      therm_r <= 14'h0;
    else if (wr_en && (paddr == `OFS_THERM))
      therm_r <= pwdata[13:0];
    else if (tick && ol_over)
      therm_r <= (therm_r + ol_rate >= `THERM_FULL) ? `THERM_FULL : therm_r + ol_rate;
    else if (tick && (therm_r != 14'h0))
      therm_r <= therm_r - 1'b1;
  end

  assign therm_usage = therm_r;

  // ==========================================
  // protection conditions
  logic [11:0] gf_lo, gf_hi, gf_trip_lvl, gf_alm_lvl;
  logic        other_alarm;

  assign gf_lo = large_frame ? `GF_LO_LARGE : `GF_LO_SMALL;
  assign gf_hi = large_frame ? `GF_HI_LARGE : `GF_HI_SMALL;
  assign gf_trip_lvl = (gf_r[11:0] < gf_lo) ? gf_lo : (gf_r[11:0] > gf_hi) ? gf_hi : gf_r[11:0];
  assign gf_alm_lvl  = (gfa_r[11:0] < gf_lo) ? gf_lo : (gfa_r[11:0] > gf_hi) ? gf_hi : gfa_r[11:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      inh_started_r <= 1'b0;
    else if ((phase_current_max == 16'h0) && (ground_leak_current < `GF_ARM_CUR))
      inh_started_r <= 1'b0;
    else if (ground_leak_current >= `GF_ARM_CUR ||
             !below_pct(phase_current_max, 16'(MIN_FLA_DECI), `MIN_FLA_PCT))
      inh_started_r <= 1'b1;
  end

  wire logic gf_armed = expd[T_INH];

  assign cond[T_UL]  = running && !slow_speed && !braking && below_pct(phase_current_max, flc_r, {3'h0, ul_r[6:0]});
  assign cond[T_UV]  = running && !braking && below_pct(line_voltage_min, volt_r, {3'h0, uv_r[6:0]});
  assign cond[T_OV]  = running && !braking && above_pct(line_voltage_max, volt_r, {2'h0, ov_r[7:0]});
  assign cond[T_UB]  = running && !braking && (unbalance_pct > {3'h0, ub_r[4:0]});
  assign cond[T_JAM] = running && !slow_speed && !braking && !ramping &&
                       above_pct(phase_current_max, flc_r, jam_r[9:0]);
  assign cond[T_STALL] = running && ramping && !up_to_speed;
  assign cond[T_STALM] = cond[T_STALL];
  assign cond[T_GF]  = gf_trip_en_r && gf_armed && (state_r != ST_TRIPPED) &&
                       (ground_leak_current >= {4'h0, gf_trip_lvl});
  assign cond[T_PTC] = ptc_en_r && (state_r != ST_TRIPPED) &&
                       ((ptc_ohms > `PTC_RESP_OHM) || (ptc_ohms < `PTC_SHORT_OHM));
  assign cond[T_GFA] = gf_alarm_en_r && gf_armed && !other_alarm &&
                       (ground_leak_current >= {4'h0, gf_alm_lvl});
  assign cond[T_INH] = inh_started_r;

  assign limit[T_UL]    = tenths({1'b0, ul_r[14:8]});
  assign limit[T_UV]    = tenths({1'b0, uv_r[22:16]});
  assign limit[T_OV]    = tenths({1'b0, ov_r[22:16]});
  assign limit[T_UB]    = tenths({1'b0, ub_r[22:16]});
  assign limit[T_JAM]   = {2'h0, jam_r[19:10]};
  assign limit[T_STALL] = tenths({3'h0, stall_r[12:8]}) + {5'h0, stall_r[6:0]};
  assign limit[T_STALM] = tenths({3'h0, stall_r[12:8]}) + {4'h0, stall_r[23:16]};
  assign limit[T_GF]    = gf_r[23:12];
  assign limit[T_PTC]   = PTC_TICKS;
  assign limit[T_GFA]   = tenths(gfa_r[19:12]);
  assign limit[T_INH]   = tenths(gfi_r[7:0]);

  for (genvar i = 0; i < NT; i++)
  begin : g_timer
    persist_timer #(.W(12)) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .cond    (cond[i]),
      .limit   (limit[i]),
      .expired (expd[i])
    );
  end

  // ==========================================
  // pre-fault alarms, no delay on the voltage levels, stall alarm after its persistence delay
  logic uv_alm, ov_alm, ub_alm;

  assign uv_alm = running && !braking && below_pct(line_voltage_min, volt_r, {3'h0, uv_r[14:8]});
  assign ov_alm = running && !braking && above_pct(line_voltage_max, volt_r, {2'h0, ov_r[15:8]});
  assign ub_alm = running && !braking && (unbalance_pct > {3'h0, ub_r[12:8]});
  assign other_alarm = uv_alm || ov_alm || ub_alm || expd[T_STALM];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alarm_r <= 1'b0;
    else
      alarm_r <= other_alarm || expd[T_GFA];
  end

  assign alarm_contact = alarm_r;

  // ==========================================
  // trip selection and run state
  fault_cause_type trip_cause;
  logic            trip_now, clear_ok;

  always_comb
  begin
    trip_cause = CAUSE_NONE;
    for (int i = T_PTC; i >= T_UL; i--)
      if (expd[i])
        trip_cause = fault_cause_type'(4'(i + 2));
    if (ol_full)
      trip_cause = CAUSE_OVERLOAD;
  end

  assign trip_now = (state_r != ST_TRIPPED) && (trip_cause != CAUSE_NONE);
  // a thermistor trip holds until the sensor has cooled below the reset level
  assign clear_ok = (reset_req_r && ((cause_r != CAUSE_THERMISTOR) || (ptc_ohms < `PTC_RESET_OHM))) ||
                    (ol_auto_r && (cause_r == CAUSE_OVERLOAD) && (therm_r < `THERM_AUTO_LVL));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_STOPPED;
      cause_r <= CAUSE_NONE;
    end
    else if (trip_now)
    begin
      state_r <= ST_TRIPPED;
      cause_r <= trip_cause;
    end
    else
    begin
      unique case (state_r)
        ST_STOPPED:
          if (start_lvl_r && start_armed_r)
            state_r <= ST_RUNNING;
        ST_RUNNING:
          if (!start_lvl_r)
            state_r <= ST_STOPPED;
        ST_TRIPPED:
          if (clear_ok)
          begin
            state_r <= ST_STOPPED;
            cause_r <= CAUSE_NONE;
          end
      endcase
    end
  end

  // start must be seen low before any run, so a held start never restarts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_armed_r <= 1'b0;
    else if (trip_now)
      start_armed_r <= 1'b0;
    else if (!start_lvl_r)
      start_armed_r <= 1'b1;
  end

  assign run_enable   = running;
  assign fault_active = (state_r == ST_TRIPPED);
  assign fault_cause  = cause_r;

  // ==========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ol_full_trip: assert property (ol_full && !fault_active |=> fault_active)
    else $error("overload at full usage did not trip");
  a_class_legal: assert property (ol_class_r <= `CLASS_30)
    else $error("illegal overload class held");
  a_restart_cycle: assert property (state_r == ST_STOPPED && !start_armed_r |=> !run_enable)
    else $error("restart without start cycling");
  a_ul_mode_quiet: assert property ((slow_speed || braking) |-> !cond[T_UL] && !cond[T_JAM])
    else $error("underload or jam checked in slow speed or braking");
  a_volt_brake_quiet: assert property (braking |-> !cond[T_UV] && !cond[T_OV] && !cond[T_UB])
    else $error("voltage checked while braking");
  a_gf_inhibit: assert property (trip_now && trip_cause == CAUSE_GROUND |-> gf_armed && gf_trip_en_r)
    else $error("ground trip before inhibit elapsed");
  a_ptc_enable: assert property (trip_now && trip_cause == CAUSE_THERMISTOR |-> ptc_en_r)
    else $error("thermistor trip while disabled");
  a_trip_latched: assert property (fault_active && !clear_ok |=> fault_active && $stable(fault_cause))
    else $error("trip released without reset");
  a_trip_stops: assert property (trip_now |=> !run_enable [*2])
    else $error("motor ran after trip");

  c_overload: cover property (trip_now && trip_cause == CAUSE_OVERLOAD);
  c_ground: cover property (trip_now && trip_cause == CAUSE_GROUND);
  c_auto_restart: cover property (fault_active && ol_auto_r ##1 !fault_active ##[1:50] run_enable);

endmodule

// ===== tb/sense_model.sv
// sensor front-end model: phase current, line voltage, leakage, thermistor
`timescale 1ns/1ps
module sense_model (
  // clock
  input  wire logic        pclk,
  // targets from the bench
  input  wire logic [15:0] cur_tgt,
  input  wire logic [15:0] volt_tgt,
  input  wire logic [15:0] ohm_tgt,
  // sensed values
  output logic      [15:0] phase_current_max   = 16'h0000,
  output logic      [15:0] line_voltage_min    = 16'h0000,
  output logic      [15:0] line_voltage_max    = 16'h0000,
  output logic      [7:0]  unbalance_pct       = 8'h00,
  output logic      [15:0] ground_leak_current = 16'h0000,
  output logic      [15:0] ptc_ohms            = 16'h0000
);
  // ==========================================
  // measurement update
  // noise stays inside every trip band, so only the targets decide faults
  always @(posedge pclk)
  begin
    phase_current_max   <= cur_tgt;
    line_voltage_min    <= volt_tgt;
    line_voltage_max    <= volt_tgt + 16'($urandom_range(8, 0));
    unbalance_pct       <= 8'($urandom_range(20, 0));
    ground_leak_current <= 16'($urandom_range(40, 0));
    ptc_ohms            <= ohm_tgt;
  end
endmodule

// ===== tb/test_motor_protect.sv
// self-checking bench for the motor protection supervisor
`timescale 1ns/1ps
`include "protect_cfg.svh"
module test_motor_protect import protect_pkg::*;;
  localparam int TK = 4;
  localparam logic [32:0] FULL = 33'h1_ffff_ffff;
  localparam logic [32:0] STM = 33'h0_0000_00f7;
  typedef struct { logic [32:0] exp; logic [32:0] msk; } note_type;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] cur_tgt = 16'h0000;
  logic [15:0] volt_tgt = 16'h0190;
  logic [15:0] ohm_tgt = 16'h03e8;
  logic        braking = 1'b0;
  logic        slow = 1'b0;
  logic        ramp = 1'b0;
  logic        start_pin = 1'b0;
  logic [15:0] cur, vmin, vmax, leak, ohms;
  logic [7:0]  ubal;
  logic        run_enable, fault_active, alarm_contact;
  logic [3:0]  fault_cause;
  logic [13:0] therm_usage;
  wire logic [9:0] pins = {alarm_contact, 1'b0, fault_cause, 1'b0, fault_active, run_enable, 1'b0};
  note_type    q[$];
  note_type    nt;
  int          err_total = 0;
  int          n_checks = 0;
  int          flc;

  always #2.5 pclk = ~pclk;

  sense_model sense_u (.pclk(pclk), .cur_tgt(cur_tgt), .volt_tgt(volt_tgt), .ohm_tgt(ohm_tgt),
    .phase_current_max(cur), .line_voltage_min(vmin), .line_voltage_max(vmax),
    .unbalance_pct(ubal), .ground_leak_current(leak), .ptc_ohms(ohms));

  motor_protect #(.TICK_CYCLES(TK), .MIN_FLA_DECI(10)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_current_max(cur),
    .line_voltage_min(vmin), .line_voltage_max(vmax), .unbalance_pct(ubal),
    .ground_leak_current(leak), .ptc_ohms(ohms), .slow_speed(slow), .braking(braking),
    .ramping(ramp), .up_to_speed(!ramp), .large_frame(1'b0), .start_pin(start_pin),
    .run_enable(run_enable), .fault_active(fault_active), .alarm_contact(alarm_contact),
    .fault_cause(fault_cause), .therm_usage(therm_usage));

  // ==========================================
  // bus driver and result monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w)
      q.push_back('{e, m});
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask

  function automatic logic [32:0] st(input fault_cause_type c, input run_state_type s);
    return {25'h0, c, 1'b0, s};
  endfunction

  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && q.size() > 0)
    begin
      nt = q.pop_front();
      n_checks++;
      if ((({pslverr, prdata} ^ nt.exp) & nt.msk) !== 33'h0)
      begin
        err_total++;
        $display("[ERR] read %h expected %h seen %h", paddr, nt.exp, {pslverr, prdata});
      end
      if (paddr == `OFS_STATUS && ((pins ^ nt.exp[9:0]) & nt.msk[9:0] & 10'h2f6) !== 10'h0)
      begin
        err_total++;
        $display("[ERR] status pins expected %h seen %h", nt.exp[9:0], pins);
      end
      if (paddr == `OFS_THERM && therm_usage !== nt.exp[13:0])
      begin
        err_total++;
        $display("[ERR] therm_usage expected %h seen %h", nt.exp[13:0], therm_usage);
      end
    end

  // ==========================================
  // scenarios
  task automatic restart();
    @(posedge pclk);
    start_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    start_pin <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  // trips must stay latched until the reset bit or the overload auto reset, then wait for a fresh start
  task automatic clear_run(input logic [31:0] ctrl);
    wr(`OFS_CTRL, ctrl);
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_STOPPED), 33'h7);
    restart();
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING), 33'h7);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge pclk);
    err_total++;
    summarize();
  end

  initial
  begin
    void'($urandom(32'hcf55));
    flc = 80 + $urandom_range(40, 0);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_CTRL, 33'h1, FULL);
    rd(`OFS_FLC, 33'h64, FULL);
    rd(`OFS_OV, 33'hc7, FULL);
    rd(8'h38, 33'h1_0000_0000, FULL);
    wr(`OFS_FLC, 32'(flc));
    rd(`OFS_FLC, 33'(flc), FULL);
    wr(`OFS_CTRL, 32'h45);
    rd(`OFS_CTRL, 33'h41, FULL);
    restart();
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING), STM);
    wr(`OFS_OV, 32'h6ec7);
    volt_tgt <= 16'd460;
    repeat (4) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING) | 33'h200, 33'h2f7);
    volt_tgt <= 16'd400;
    repeat (4) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING), 33'h2f7);
    // thermistor: not before the response time, then latched
    ohm_tgt <= 16'd3500;
    repeat (TK * 6) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING), STM);
    repeat (TK * 4) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_THERMISTOR, ST_TRIPPED), STM);
    wr(`OFS_CTRL, 32'h141);
    rd(`OFS_STATUS, st(CAUSE_THERMISTOR, ST_TRIPPED), STM);
    ohm_tgt <= 16'd1000;
    repeat (4) @(posedge pclk);
    clear_run(32'h141);
    ohm_tgt <= 16'd10;
    repeat (TK * 10) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_THERMISTOR, ST_TRIPPED), STM);
    ohm_tgt <= 16'd1000;
    repeat (4) @(posedge pclk);
    clear_run(32'h141);
    // undervoltage held off by braking, then first cause kept
    wr(`OFS_UV, 32'h0000_005a);
    braking <= 1'b1;
    volt_tgt <= 16'd300;
    repeat (TK * 6) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING), STM);
    braking <= 1'b0;
    repeat (TK * 4) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_UNDERVOLT, ST_TRIPPED), STM);
    ohm_tgt <= 16'd3500;
    repeat (TK * 10) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_UNDERVOLT, ST_TRIPPED), STM);
    ohm_tgt <= 16'd1000;
    volt_tgt <= 16'd400;
    repeat (4) @(posedge pclk);
    clear_run(32'h141);
    // underload held off in slow speed; stall past a 1 s ramp
    slow <= 1'b1;
    wr(`OFS_UL, 32'h32);
    repeat (TK * 4) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING), STM);
    slow <= 1'b0;
    repeat (TK * 4) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_UNDERLOAD, ST_TRIPPED), STM);
    cur_tgt <= 16'(flc);
    clear_run(32'h141);
    wr(`OFS_STALL, 32'h100);
    ramp <= 1'b1;
    repeat (TK * 8) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING), STM);
    repeat (TK * 6) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_STALL, ST_TRIPPED), STM);
    ramp <= 1'b0;
    clear_run(32'h141);
    // overload around the 117 percent pickup, from a restored usage
    cur_tgt <= 16'(flc * 117 / 100 - 2);
    wr(`OFS_THERM, 32'd9990);
    repeat (TK * 4) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING), STM);
    cur_tgt <= 16'(flc * 117 / 100 + 3);
    repeat (TK * 4) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_OVERLOAD, ST_TRIPPED), STM);
    rd(`OFS_THERM, 33'h2710, FULL);
    // auto reset below the restart level, then class off
    cur_tgt <= 16'(flc);
    wr(`OFS_THERM, 32'd7000);
    clear_run(32'h49);
    cur_tgt <= 16'(flc * 117 / 100 + 3);
    wr(`OFS_CTRL, 32'h40);
    wr(`OFS_THERM, 32'd9990);
    repeat (TK * 4) @(posedge pclk);
    rd(`OFS_STATUS, st(CAUSE_NONE, ST_RUNNING), STM);
    repeat (4) @(posedge pclk);
    summarize();
  end
endmodule
